// *** hdl/fsb_pkg.sv ***
// Shared constants for the synchronous FIFO bus port.
// Assumes a single system clock at SYS_HZ and a synchronous reset.
package fsb_pkg;
    // System clock rate
    localparam int SYS_HZ        = 20_000_000;
    // Selectable bus clock rates, Hz
    localparam int BUS_HZ_SLOW   = 66_000_000;
    localparam int BUS_HZ_FAST   = 100_000_000;
    // Half period in system cycles, rounded down, never below one
    localparam int HALF_SLOW_RAW = SYS_HZ / (2 * BUS_HZ_SLOW);
    localparam int HALF_FAST_RAW = SYS_HZ / (2 * BUS_HZ_FAST);
    localparam int HALF_SLOW     = (HALF_SLOW_RAW < 1) ? 1 : HALF_SLOW_RAW;
    localparam int HALF_FAST     = (HALF_FAST_RAW < 1) ? 1 : HALF_FAST_RAW;
    // Bus, lane and divider counter widths
    localparam int DATA_W_WIDE   = 32;
    localparam int DATA_W_NARROW = 16;
    localparam int LANE_W        = 8;
    localparam int DIV_CNT_W     = 8;
    // Reset levels of the active-low flags (deasserted)
    localparam logic FLAG_IDLE_N = 1'b1;
endpackage : fsb_pkg

// *** hdl/fsb_clk_div.sv ***
// Bus clock divider: drives the bus clock and a one-cycle rise enable.
// Assumes sys_clk is the only clock; rst is synchronous, active high.
`timescale 1ns/10ps
module fsb_clk_div #(
    parameter int HALF_SLOW = fsb_pkg::HALF_SLOW,
    parameter int HALF_FAST = fsb_pkg::HALF_FAST
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic fast_sel,
    output logic      bus_clk_q,
    output logic      rise_q
);
    localparam int CW = fsb_pkg::DIV_CNT_W;

    // Refuse half periods the counter cannot hold
    initial begin
        if (HALF_SLOW < 1 || HALF_SLOW > (1 << CW) - 1 ||
            HALF_FAST < 1 || HALF_FAST > (1 << CW) - 1) begin
            $error("fsb_clk_div: half period out of range");
        end
    end

    logic [CW-1:0] cnt_q;
    wire  [CW-1:0] reload_w = fast_sel ? CW'(HALF_FAST - 1)
                                       : CW'(HALF_SLOW - 1);

    // Count down a half period, then toggle the bus clock
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q     <= '0;
            bus_clk_q <= 1'b0;
            rise_q    <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q     <= reload_w;
            bus_clk_q <= ~bus_clk_q;
            rise_q    <= ~bus_clk_q;   // High with the rising bus edge
        end else begin
            cnt_q     <= cnt_q - CW'(1);
            rise_q    <= 1'b0;
        end
    end
endmodule : fsb_clk_div

// *** hdl/fsb_port.sv ***
// Device end of the parallel synchronous FIFO bus.
// Assumes the master samples and launches on the rising bus clock edge
// and that the user side runs on sys_clk.
//
// Contract
// [R1] Device drives the bus clock out, at a slow or fast selectable rate; here both selects give SYS_HZ/2.
// [R2] Data word is two-way; each side drives it only in its direction.
// [R3] Narrow variant: sixteen data bits and two byte lane enables.
// [R4] Byte lane enables travel with data, driven by the data source.
// [R5] Single-channel: space flag low only while a byte of space is free.
// [R6] Master writes only while the space flag is low.
// [R7] Multi-channel: space flag pin carries a status-valid indication.
// [R8] Single-channel: data flag low when a byte is available to read.
// [R9] Master reads only while the data flag shows data available.
// [R10] Write strobe: write enable single-channel, request multi-channel.
// [R11] Single-channel: output enable lets device drive data to master.
// [R12] All bus signals launched and sampled on the rising bus clock.
`timescale 1ns/10ps
module fsb_port #(
    parameter int DATA_W = fsb_pkg::DATA_W_WIDE,
    parameter int BE_W   = DATA_W / fsb_pkg::LANE_W
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              clk_fast_sel,
    input  wire logic              multi_channel_mode,
    output logic                   bus_clk,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    input  wire logic [BE_W-1:0]   byte_lane_enable_in,
    output logic      [BE_W-1:0]   byte_lane_enable_out,
    output logic                   byte_lane_enable_oe,
    output logic                   tx_space_avail_n,
    output logic                   rx_data_avail_n,
    input  wire logic              wr_strobe_n,
    input  wire logic              rd_strobe_n,
    input  wire logic              out_enable_n,
    input  wire logic              usr_wr_space,
    input  wire logic              usr_status_valid,
    output logic                   usr_wr_valid,
    output logic                   usr_req,
    output logic      [DATA_W-1:0] usr_wr_data,
    output logic      [BE_W-1:0]   usr_wr_be,
    input  wire logic              usr_rd_valid,
    input  wire logic [DATA_W-1:0] usr_rd_data,
    input  wire logic [BE_W-1:0]   usr_rd_be,
    output logic                   usr_rd_ready
);
    // Only the wide and narrow variants exist
    initial begin
        if (!(DATA_W == fsb_pkg::DATA_W_WIDE ||
              DATA_W == fsb_pkg::DATA_W_NARROW) ||
            BE_W != DATA_W / fsb_pkg::LANE_W) begin   // see [R3]
            $error("fsb_port: unsupported bus width");
        end
    end

    // Strobe taken on a bus edge while low
    function automatic logic fsb_take(input logic strobe_n,
                                      input logic rise);
        fsb_take = rise & ~strobe_n;
    endfunction : fsb_take

    logic bus_rise;

    // Bus clock and its rising-edge enable
    fsb_clk_div #(
        .HALF_SLOW (fsb_pkg::HALF_SLOW),
        .HALF_FAST (fsb_pkg::HALF_FAST)
    ) u_div (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .fast_sel  (clk_fast_sel),
        .bus_clk_q (bus_clk),
        .rise_q    (bus_rise)
    );                                                   // see [R1]

    // Two-stage synchronisers on every pin input
    logic [DATA_W-1:0] data_m_q,   data_s_q;
    logic [BE_W-1:0]   be_m_q,     be_s_q;
    logic [2:0]        ctl_m_q,    ctl_s_q;
    always_ff @(posedge sys_clk) begin
        data_m_q <= data_in;
        data_s_q <= data_m_q;
        be_m_q   <= byte_lane_enable_in;
        be_s_q   <= be_m_q;
        ctl_m_q  <= {wr_strobe_n, rd_strobe_n, out_enable_n};
        ctl_s_q  <= ctl_m_q;
    end
    wire wr_n_s = ctl_s_q[2];
    wire rd_n_s = ctl_s_q[1];
    wire oe_n_s = ctl_s_q[0];

    // Flag registers and bus drive state
    logic              tx_n_q, rx_n_q, data_oe_q;
    logic [DATA_W-1:0] data_out_q;
    logic [BE_W-1:0]   be_out_q;
    logic              hold_valid_q;
    logic [DATA_W-1:0] hold_data_q;
    logic [BE_W-1:0]   hold_be_q;
    logic              usr_wr_valid_q, usr_req_q, usr_rd_ready_q;
    logic [DATA_W-1:0] usr_wr_data_q;
    logic [BE_W-1:0]   usr_wr_be_q;

    // Decode of bus events
    wire write_take = fsb_take(wr_n_s, bus_rise) & ~multi_channel_mode
                      & ~tx_n_q;                          // see [R6] [R10]
    wire req_take   = fsb_take(wr_n_s, bus_rise) & multi_channel_mode;
    wire read_perm  = multi_channel_mode ? ~rd_n_s
                                         : ~oe_n_s;       // see [R11]
    wire drive_d    = read_perm & hold_valid_q & wr_n_s;  // see [R2]
    wire read_take  = fsb_take(rd_n_s, bus_rise) & data_oe_q
                      & hold_valid_q & ~rx_n_q;           // see [R9]
    wire load_hold  = usr_rd_valid & usr_rd_ready_q;
    wire tx_n_d     = multi_channel_mode ? ~usr_status_valid
                                         : ~usr_wr_space; // see [R5] [R7]

    // Flags and drive are launched only on a rising bus edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_n_q     <= fsb_pkg::FLAG_IDLE_N;
            rx_n_q     <= fsb_pkg::FLAG_IDLE_N;
            data_oe_q  <= 1'b0;
            data_out_q <= '0;
            be_out_q   <= '0;
        end else if (bus_rise) begin                      // see [R12]
            tx_n_q     <= tx_n_d;                         // see [R5] [R7]
            rx_n_q     <= ~hold_valid_q;                  // see [R8]
            data_oe_q  <= drive_d;                        // see [R2]
            data_out_q <= hold_data_q;
            be_out_q   <= hold_be_q;                      // see [R4]
        end
    end

    // One-word holding register toward the master
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_valid_q   <= 1'b0;
            hold_data_q    <= '0;
            hold_be_q      <= '0;
            usr_rd_ready_q <= 1'b0;
        end else begin
            if (load_hold) begin
                hold_valid_q <= 1'b1;
                hold_data_q  <= usr_rd_data;
                hold_be_q    <= usr_rd_be;
            end else if (read_take) begin
                hold_valid_q <= 1'b0;                     // see [R8]
            end
            usr_rd_ready_q <= ~hold_valid_q & ~load_hold;
        end
    end

    // Words written by the master, handed to the user side
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            usr_wr_valid_q <= 1'b0;
            usr_req_q      <= 1'b0;
            usr_wr_data_q  <= '0;
            usr_wr_be_q    <= '0;
        end else begin
            usr_wr_valid_q <= write_take;                 // see [R10]
            usr_req_q      <= req_take;                   // see [R10]
            if (write_take) begin
                usr_wr_data_q <= data_s_q;
                usr_wr_be_q   <= be_s_q;                  // see [R4]
            end
        end
    end

    // Port outputs, all from flip-flops
    assign tx_space_avail_n     = tx_n_q;
    assign rx_data_avail_n      = rx_n_q;
    assign data_out             = data_out_q;
    assign data_oe              = data_oe_q;
    assign byte_lane_enable_out = be_out_q;
    assign byte_lane_enable_oe  = data_oe_q;              // see [R4]
    assign usr_wr_valid         = usr_wr_valid_q;
    assign usr_req              = usr_req_q;
    assign usr_wr_data          = usr_wr_data_q;
    assign usr_wr_be            = usr_wr_be_q;
    assign usr_rd_ready         = usr_rd_ready_q;

    // Checks
    localparam int AST_HALF_MAX = 2 * ((1 << fsb_pkg::DIV_CNT_W) - 1);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_write_seen;
        bus_rise && !multi_channel_mode && !wr_n_s && !tx_n_q;
    endsequence
    sequence s_handoff;
        usr_wr_valid_q ##1 !usr_wr_valid_q;
    endsequence

    AST_BUS_CLK_RISE: assert property (bus_rise |-> bus_clk) // see [R1]
        else $error("bus edge enable without bus clock high");
    AST_BUS_CLK_RUNS: assert property (                      // see [R1]
        !bus_clk |-> ##[1:AST_HALF_MAX] bus_clk)
        else $error("bus clock stuck low");
    AST_TX_SPACE: assert property (                          // see [R5]
        bus_rise && !multi_channel_mode && usr_wr_space |=> !tx_n_q)
        else $error("space flag not low with space free");
    AST_TX_FULL: assert property (                           // see [R5]
        bus_rise && !multi_channel_mode && !usr_wr_space |=> tx_n_q)
        else $error("space flag low with no space");
    AST_STATUS_VALID: assert property (                      // see [R7]
        bus_rise && multi_channel_mode
        |=> tx_n_q == !$past(usr_status_valid))
        else $error("status valid not shown on space pin");
    AST_RX_FLAG: assert property (                           // see [R8]
        bus_rise |=> rx_n_q == !$past(hold_valid_q))
        else $error("data flag does not follow held word");
    AST_NO_CLASH: assert property (                          // see [R2]
        bus_rise && !wr_n_s |=> !data_oe_q)
        else $error("device drives data during master write");
    AST_BE_WITH_DATA: assert property (                      // see [R4]
        (byte_lane_enable_oe == data_oe) && (!data_oe || !rx_n_q))
        else $error("lane enables drive apart from data");
    AST_WRITE_CAPTURE: assert property (                     // see [R6]
        s_write_seen |=> s_handoff
        and (usr_wr_data_q == $past(data_s_q)))
        else $error("master write not handed over");
    AST_READ_DRAIN: assert property (read_take |=> !hold_valid_q) // see [R9]
        else $error("held word not released after read");
endmodule : fsb_port

// *** verification/fsb_master_model.sv ***
// Behavioural bus master facing the device pins of the FIFO bus port.
// Assumes launches on falling sys_clk edges, bus half period of one cycle.
`timescale 1ns/10ps
module fsb_master_model #(
    parameter int DW = 32,
    parameter int BW = 4
) (
    input  wire logic          sys_clk,
    input  wire logic          bus_clk,
    input  wire logic [DW-1:0] d_out,
    input  wire logic          d_oe,
    input  wire logic [BW-1:0] b_out,
    input  wire logic          tx_n,
    input  wire logic          rx_n,
    output logic      [DW-1:0] d_in,
    output logic      [BW-1:0] b_in,
    output logic               wr_n,
    output logic               rd_n,
    output logic               oe_n
);
    logic          drv = 1'b0;
    logic          rude = 1'b0;
    logic [DW-1:0] dat = '0;
    logic [BW-1:0] be = '0;
    logic [DW-1:0] last_d = '0;
    logic [BW-1:0] last_b = '0;
    int            n;

    // Idle strobes
    initial begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        oe_n = 1'b1;
    end
    // Shared wires: device wins, released lines show inverse of last drive
    assign d_in = d_oe ? d_out : (drv ? dat : ~last_d);
    assign b_in = d_oe ? b_out : (drv ? be : ~last_b);
    always @(posedge sys_clk) begin
        if (d_oe === 1'b1 || drv) begin
            last_d <= d_in;
            last_b <= b_in;
        end
    end

    // Burst of words, strobe held low throughout, two cycles a word
    task automatic write_words(input int cnt, input logic [DW-1:0] d0);
        for (n = 0; n < 40 && tx_n !== 1'b0 && !rude; n++)
            @(negedge sys_clk);
        for (int i = 0; i < cnt; i++) begin
            @(negedge sys_clk);
            drv = 1'b1;
            wr_n = 1'b0;
            dat = d0 + DW'(i);
            be = BW'(i + 1);
            @(negedge sys_clk);
        end
        @(negedge sys_clk);
        wr_n = 1'b1;
        drv = 1'b0;
    endtask : write_words

    // One word toward the master: wait for data, enable, strobe once
    task automatic read_word(output logic [DW-1:0] d,
                             output logic [BW-1:0] b);
        for (n = 0; n < 40 && rx_n !== 1'b0; n++)
            @(negedge sys_clk);
        oe_n = 1'b0;
        for (n = 0; n < 40 && d_oe !== 1'b1; n++)
            @(negedge sys_clk);
        @(posedge bus_clk);
        d = d_in;
        b = b_in;
        @(negedge sys_clk);
        rd_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rd_n = 1'b1;
        oe_n = 1'b1;
    endtask : read_word
endmodule : fsb_master_model

// *** verification/test_sync_fifo_bus_port.sv ***
// Self-checking bench for the FIFO bus port, wide variant.
// Assumes the master model owns the pin side of the port.
`timescale 1ns/10ps
module test_sync_fifo_bus_port;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_fast_sel = 1'b0;
    logic        multi_channel_mode = 1'b0;
    logic        usr_wr_space = 1'b1;
    logic        usr_status_valid = 1'b0;
    logic        usr_rd_valid = 1'b0;
    logic [31:0] usr_rd_data = 32'h0;
    logic [3:0]  usr_rd_be = 4'h0;
    logic [31:0] data_in, data_out, usr_wr_data, d, wdq[$];
    logic [3:0]  byte_lane_enable_in, byte_lane_enable_out, usr_wr_be, b;
    logic [3:0]  wbq[$];
    logic        bus_clk, data_oe, tx_space_avail_n, rx_data_avail_n, be_oe;
    logic        wr_strobe_n, rd_strobe_n, out_enable_n;
    logic        usr_wr_valid, usr_req, usr_rd_ready;
    int          fail_count = 0, comparisons = 0;
    int          rises = 0, reqs = 0, clash = 0, n, n0, r0, be_on = 0;

    fsb_port DUT (.sys_clk, .rst, .clk_fast_sel, .multi_channel_mode,
        .bus_clk, .data_in, .data_out, .data_oe, .byte_lane_enable_in,
        .byte_lane_enable_out, .byte_lane_enable_oe(be_oe), .tx_space_avail_n,
        .rx_data_avail_n, .wr_strobe_n, .rd_strobe_n, .out_enable_n,
        .usr_wr_space, .usr_status_valid, .usr_wr_valid, .usr_req,
        .usr_wr_data, .usr_wr_be, .usr_rd_valid, .usr_rd_data, .usr_rd_be,
        .usr_rd_ready);
    fsb_master_model master (.sys_clk, .bus_clk, .d_out(data_out),
        .d_oe(data_oe), .b_out(byte_lane_enable_out),
        .tx_n(tx_space_avail_n), .rx_n(rx_data_avail_n), .d_in(data_in),
        .b_in(byte_lane_enable_in), .wr_n(wr_strobe_n), .rd_n(rd_strobe_n),
        .oe_n(out_enable_n));

    // Clock, bus clock edge count, watchdog
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge bus_clk) rises++;
    initial begin
        #(50 * 3000);
        fail_count++;
        complete_run;
    end
    // Log user-side words, requests and lane drive mid-cycle
    always @(negedge sys_clk) begin
        if (usr_wr_valid === 1'b1) begin
            wdq.push_back(usr_wr_data);
            wbq.push_back(usr_wr_be);
        end
        if (usr_req === 1'b1)
            reqs++;
        if (be_oe === 1'b1)
            be_on++;
    end
    // Drive clashes, and lane drive apart from data drive
    always @(posedge sys_clk) begin
        if (data_oe !== 1'b0 && wr_strobe_n === 1'b0)
            clash++;
        if (be_oe !== data_oe)
            clash++;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task complete_run;
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // Bus clock runs at the divided rate for both selects
    task t_clock;
        for (int s = 0; s < 2; s++) begin
            clk_fast_sel = s[0];
            repeat (2) @(negedge sys_clk);
            r0 = rises;
            repeat (20) @(negedge sys_clk);
            check(32'(rises - r0), 32'(20 / (2 * (s ? fsb_pkg::HALF_FAST
                : fsb_pkg::HALF_SLOW))));
        end
    endtask : t_clock

    // Space flag in single mode, status flag in multi mode
    task t_flags;
        for (int k = 0; k < 4; k++) begin
            multi_channel_mode = k[1];
            usr_status_valid = k[0];
            usr_wr_space = k[0] ^ k[1];
            repeat (8) @(negedge sys_clk);
            check(32'(tx_space_avail_n), 32'(!k[0]));
        end
        multi_channel_mode = 1'b0;
        usr_wr_space = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask : t_flags

    // Back-to-back writes, then a write against a full device
    task t_write;
        n0 = wdq.size();
        master.write_words(2, 32'hA5A5_0010);
        repeat (8) @(negedge sys_clk);
        check(32'(wdq.size() - n0), 32'h2);
        check(wdq[n0 + 1], 32'hA5A5_0011);
        check(32'(wbq[n0 + 1]), 32'h2);
        usr_wr_space = 1'b0;
        repeat (8) @(negedge sys_clk);
        master.rude = 1'b1;
        master.write_words(1, 32'h0BAD_0000);
        repeat (8) @(negedge sys_clk);
        check(32'(wdq.size() - n0), 32'h2);
        master.rude = 1'b0;
        usr_wr_space = 1'b1;
    endtask : t_write

    // Multi-channel strobe is a request, never a data word
    task t_multi;
        multi_channel_mode = 1'b1;
        usr_status_valid = 1'b1;
        n0 = wdq.size();
        r0 = reqs;
        master.write_words(1, 32'h0000_7777);
        repeat (8) @(negedge sys_clk);
        check(32'(reqs - r0), 32'h1);
        check(32'(wdq.size() - n0), 32'h0);
        multi_channel_mode = 1'b0;
    endtask : t_multi

    // Word from the user side read out by the master
    task t_read;
        usr_rd_data = 32'h1234_ABCD;
        usr_rd_be = 4'h9;
        usr_rd_valid = 1'b1;
        // Valid held through the rising edge that sees ready high
        for (n = 0; n < 20 && usr_rd_ready !== 1'b1; n++)
            @(negedge sys_clk);
        @(negedge sys_clk);
        usr_rd_valid = 1'b0;
        repeat (8) @(negedge sys_clk);
        check(32'(rx_data_avail_n), 32'h0);
        master.read_word(d, b);
        check(d, 32'h1234_ABCD);
        check(32'(b), 32'h9);
        repeat (8) @(negedge sys_clk);
        check(32'(rx_data_avail_n), 32'h1);
        check(32'(clash), 32'h0);
        check(32'(be_on > 0), 32'h1);
    endtask : t_read

    // Reset, then the scenarios in turn
    initial begin
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(32'(data_oe), 32'h0);
        t_clock;
        t_flags;
        t_write;
        t_multi;
        t_read;
        complete_run;
    end
endmodule : test_sync_fifo_bus_port
